// ==== design/rpsm_top.sv ====
// Operation
// - Hold in reset until supply good; load defaults
// - Set power-on flag after defaults load
// - Start fast supply scan once oscillator runs
// - Above second threshold: stop fast scan, read NVM
// - Load config from NVM, clear low flags
// - Then scan supply every one second
// - Thermometer enabled: measure and compensate before ready
// - Scan below first threshold sets first flag
// - Low flags drive interrupt when enabled
// - Low supply disables sensitive functions
// - Backup supply disables serial port, clock output
// - Interrupt output still works on backup supply
// - Trickle charge only if selected, off on backup
// - Eight-bit quadratic crystal coefficient register
// - Turnover temperature in bits 5..0, upper unused
// - Scan below second threshold sets second flag
`timescale 1ns/1ps
`include "rpsm_regs.svh"

module rpsm_top
  import rpsm_pkg::*;
#(
  parameter int FAST_SCAN_CYCLES = `RPSM_CLK_HZ / `RPSM_MS_PER_S * `RPSM_FAST_SCAN_MS,
  parameter int SLOW_SCAN_CYCLES = `RPSM_CLK_HZ / `RPSM_MS_PER_S * `RPSM_SLOW_SCAN_MS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic supplyAbovePor,
  input wire logic oscReady,
  input wire logic aboveLow1,
  input wire logic aboveLow2,
  input wire logic onBackup,
  input wire logic measureDone,
  input wire logic spiChipSelectN,
  input wire logic spiClock,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOeN,
  output logic intN,
  output logic fastScan,
  output logic nvmReadEnable,
  output logic measureStart,
  output logic thermometerEnable,
  output logic deviceReady,
  output logic clockOutEnable,
  output logic [1:0] clockOutSelect,
  output logic [3:0] trickleSelect,
  output logic [7:0] xtalOffset,
  output logic [7:0] xtalCoef,
  output logic [5:0] xtalT0
);
  import rpsm_pkg::*;

  logic rstnMeta;
  logic rstnSync;
  rpsm_top_state_t st_r;
  rpsm_top_state_t st_nxt;
  logic scanTick;
  logic [7:0] nvmRdData;
  logic nvmWrEn;
  logic [1:0] nvmWrAddr;
  logic [7:0] nvmWrData;
  logic [7:0] rxByte;
  logic [7:0] rdByte;
  logic [5:0] nextAddr;
  logic sclRise;
  logic sclFall;
  logic spiActive;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstnMeta <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstnMeta <= 1'b1;
      rstnSync <= rstnMeta;
    end
  end

  function automatic logic [7:0] regRead(input logic [5:0] a, input rpsm_top_state_t s);
    logic [7:0] d;
    d = `RPSM_BYTE_ZERO;
    case (a)
      `RPSM_ADDR_CTRL_INT: d = s.ctrlInt;
      `RPSM_ADDR_STATUS: begin
        d[`RPSM_ST_PON] = s.power_on_flag;
        d[`RPSM_ST_LOW1] = s.low1;
        d[`RPSM_ST_LOW2] = s.low2;
      end
      `RPSM_ADDR_NV_CTRL: d = s.nvCtrl;
      `RPSM_ADDR_XTAL_OFS: d = s.xtalOffset;
      `RPSM_ADDR_CRYSTAL_QUADRATIC_COEFFICIENT: d = s.xtalCoef;
      `RPSM_ADDR_CRYSTAL_TURNOVER_TEMPERATURE: d = {2'h0, s.xtalT0[`RPSM_T0_MSB:0]};
      default: d = `RPSM_BYTE_ZERO;
    endcase
    return d;
  endfunction

  rpsm_scan #(
    .COUNT_W(25),
    .FAST_CYCLES(25'(FAST_SCAN_CYCLES)),
    .SLOW_CYCLES(25'(SLOW_SCAN_CYCLES))
  ) scanTimer (
    .clock(clock),
    .rstn(rstnSync),
    .enable(st_r.seq == SEQ_FAST_SCAN || st_r.seq == SEQ_NVM_LOAD ||
            st_r.seq == SEQ_MEASURE || st_r.seq == SEQ_RUN),
    .fast(st_r.seq == SEQ_FAST_SCAN),
    .tick(scanTick)
  );

  rpsm_nvm controlPage (
    .clock(clock),
    .rstn(rstnSync),
    .wrEn(nvmWrEn),
    .wrAddr(nvmWrAddr),
    .wrData(nvmWrData),
    .rdAddr(st_r.loadIdx[1:0]),
    .rdData(nvmRdData)
  );

  // Serial port is shut off entirely on the backup supply
  assign spiActive = !spiChipSelectN && !onBackup;
  assign sclRise = spiActive && spiClock && !st_r.sclPrev;
  assign sclFall = spiActive && !spiClock && st_r.sclPrev;

  always_comb begin
    st_nxt = st_r;
    st_nxt.measureStart = 1'b0;
    st_nxt.sclPrev = spiClock;
    nvmWrEn = 1'b0;
    nvmWrAddr = 2'h0;
    nvmWrData = `RPSM_BYTE_ZERO;
    rxByte = {st_r.shiftIn[6:0], spiMosi};
    nextAddr = st_r.addr + 6'h01;
    rdByte = regRead(nextAddr, st_r);

    // Serial register access: command byte, then data bytes with auto-increment
    if (!spiActive) begin
      st_nxt.bitCnt = 4'h0;
      st_nxt.cmdDone = 1'b0;
      st_nxt.isRead = 1'b0;
    end else if (sclRise) begin
      st_nxt.shiftIn = rxByte;
      st_nxt.bitCnt = st_r.bitCnt + 4'h1;
      if (st_r.bitCnt == `RPSM_SPI_LAST_BIT) begin
        st_nxt.bitCnt = 4'h0;
        if (!st_r.cmdDone) begin
          st_nxt.cmdDone = 1'b1;
          st_nxt.isRead = rxByte[`RPSM_SPI_RD_BIT];
          st_nxt.addr = rxByte[5:0];
          st_nxt.shiftOut = regRead(rxByte[5:0], st_r);
        end else if (st_r.isRead) begin
          st_nxt.addr = nextAddr;
          st_nxt.shiftOut = rdByte;
        end else begin
          st_nxt.addr = nextAddr;
          case (st_r.addr)
            `RPSM_ADDR_CTRL_INT: st_nxt.ctrlInt = rxByte;
            `RPSM_ADDR_STATUS: begin
              // Writing zero clears a flag, writing one leaves it
              st_nxt.power_on_flag = st_r.power_on_flag & rxByte[`RPSM_ST_PON];
              st_nxt.low1 = st_r.low1 & rxByte[`RPSM_ST_LOW1];
              st_nxt.low2 = st_r.low2 & rxByte[`RPSM_ST_LOW2];
            end
            `RPSM_ADDR_NV_CTRL, `RPSM_ADDR_XTAL_OFS, `RPSM_ADDR_CRYSTAL_QUADRATIC_COEFFICIENT: begin
              nvmWrEn = 1'b1;
              nvmWrAddr = st_r.addr[1:0];
              nvmWrData = rxByte;
            end
            `RPSM_ADDR_CRYSTAL_TURNOVER_TEMPERATURE: begin
              nvmWrEn = 1'b1;
              nvmWrAddr = st_r.addr[1:0];
              nvmWrData = {2'h0, rxByte[`RPSM_T0_MSB:0]};
            end
            default: nvmWrEn = 1'b0;
          endcase
          if (nvmWrEn) begin
            case (st_r.addr[1:0])
              2'h0: st_nxt.nvCtrl = nvmWrData;
              2'h1: st_nxt.xtalOffset = nvmWrData;
              2'h2: st_nxt.xtalCoef = nvmWrData;
              default: st_nxt.xtalT0 = nvmWrData;
            endcase
          end
        end
      end
    end else if (sclFall && st_r.cmdDone && st_r.isRead) begin
      st_nxt.misoOut = st_r.shiftOut[7];
      st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
    end

    // Periodic supply scan; a set lands after a serial-port clear in the same cycle
    if (scanTick) begin
      st_nxt.below1 = !aboveLow1;
      st_nxt.below2 = !aboveLow2;
      if (!aboveLow1) begin
        st_nxt.low1 = 1'b1;
      end
      if (!aboveLow2) begin
        st_nxt.low2 = 1'b1;
      end
    end

    case (st_r.seq)
      SEQ_HOLD: begin
        st_nxt.seq = SEQ_DEFAULTS;
      end
      SEQ_DEFAULTS: begin
        st_nxt.ctrlInt = `RPSM_CTRL_INT_RST;
        st_nxt.low1 = 1'b0;
        st_nxt.low2 = 1'b0;
        st_nxt.power_on_flag = 1'b1;
        st_nxt.seq = SEQ_WAIT_OSC;
      end
      SEQ_WAIT_OSC: begin
        if (oscReady) begin
          st_nxt.seq = SEQ_FAST_SCAN;
        end
      end
      SEQ_FAST_SCAN: begin
        if (scanTick && aboveLow2) begin
          st_nxt.seq = SEQ_NVM_LOAD;
          st_nxt.loadIdx = 3'h0;
        end
      end
      SEQ_NVM_LOAD: begin
        st_nxt.loadIdx = st_r.loadIdx + 3'h1;
        if (st_r.loadIdx != 3'h0) begin
          case (st_r.loadIdx)
            3'h1: st_nxt.nvCtrl = nvmRdData;
            3'h2: st_nxt.xtalOffset = nvmRdData;
            3'h3: st_nxt.xtalCoef = nvmRdData;
            default: st_nxt.xtalT0 = nvmRdData;
          endcase
        end
        if (st_r.loadIdx == 3'(`RPSM_NV_WORDS)) begin
          // The power-up clearing step wins over a scan in the same cycle
          st_nxt.low1 = 1'b0;
          st_nxt.low2 = 1'b0;
          st_nxt.below1 = 1'b0;
          st_nxt.below2 = 1'b0;
          st_nxt.loadIdx = 3'h0;
          if (st_r.nvCtrl[`RPSM_NV_THE]) begin
            st_nxt.seq = SEQ_MEASURE;
            st_nxt.measureStart = 1'b1;
          end else begin
            st_nxt.seq = SEQ_RUN;
          end
        end
      end
      SEQ_MEASURE: begin
        if (measureDone) begin
          st_nxt.seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        st_nxt.seq = SEQ_RUN;
      end
      default: begin
        st_nxt.seq = SEQ_HOLD;
      end
    endcase

    // All rpsm_top state but sclPrev falls back to reset while the supply is under threshold; the NVM keeps its contents
    if (!supplyAbovePor) begin
      st_nxt = '0;
      st_nxt.seq = SEQ_HOLD;
      st_nxt.sclPrev = spiClock;
    end
  end

  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Interrupt logic is not gated by the backup supply
  assign intN = !((st_r.low1 && st_r.ctrlInt[`RPSM_IE_LOW1]) ||
                  (st_r.low2 && st_r.ctrlInt[`RPSM_IE_LOW2]));
  assign spiMiso = st_r.misoOut;
  assign spiMisoOeN = !(spiActive && st_r.cmdDone && st_r.isRead);
  assign fastScan = (st_r.seq == SEQ_FAST_SCAN);
  assign nvmReadEnable = (st_r.seq == SEQ_NVM_LOAD) && !st_r.below2;
  assign measureStart = st_r.measureStart;
  assign thermometerEnable = st_r.nvCtrl[`RPSM_NV_THE] && !st_r.below1 &&
                             (st_r.seq == SEQ_MEASURE || st_r.seq == SEQ_RUN);
  assign deviceReady = (st_r.seq == SEQ_RUN);
  assign clockOutEnable = deviceReady && !onBackup;
  assign clockOutSelect = st_r.nvCtrl[`RPSM_NV_FD_HI:`RPSM_NV_FD_LO];
  assign trickleSelect = onBackup ? 4'h0 : st_r.nvCtrl[`RPSM_NV_TRK_HI:`RPSM_NV_TRK_LO];
  assign xtalOffset = st_r.xtalOffset;
  assign xtalCoef = st_r.xtalCoef;
  assign xtalT0 = st_r.xtalT0[`RPSM_T0_MSB:0];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstnSync);

  AST_HOLD_RESET: assert property (!supplyAbovePor |=> st_r.seq == SEQ_HOLD && !st_r.power_on_flag)
    else $error("not held in reset under low supply");
  AST_PON_SET: assert property (st_r.seq == SEQ_DEFAULTS && supplyAbovePor |=> st_r.power_on_flag && !st_r.low1)
    else $error("power-on flag not set after defaults");
  AST_FAST_START: assert property (st_r.seq == SEQ_WAIT_OSC && oscReady && supplyAbovePor |=> fastScan)
    else $error("fast scan did not start");
  AST_FAST_END: assert property (fastScan && scanTick && aboveLow2 && supplyAbovePor
                                 |=> !fastScan && st_r.seq == SEQ_NVM_LOAD)
    else $error("fast scan did not end");
  AST_LOAD_CLEAR: assert property (st_r.seq == SEQ_NVM_LOAD && supplyAbovePor &&
                                   st_r.loadIdx == 3'(`RPSM_NV_WORDS)
                                   |=> !st_r.low1 && !st_r.low2 && st_r.nvCtrl == $past(nvmRdData, 4))
    else $error("load did not clear flags");
  AST_MEASURE: assert property (st_r.measureStart |-> st_r.nvCtrl[`RPSM_NV_THE] && !deviceReady)
    else $error("measurement started without thermometer enable");
  AST_LOW1_SET: assert property (scanTick && !aboveLow1 && supplyAbovePor && st_r.seq == SEQ_RUN
                                 ##1 st_r.ctrlInt[`RPSM_IE_LOW1] |-> !intN)
    else $error("first low flag did not raise interrupt");
  AST_LOW2_SET: assert property (scanTick && !aboveLow2 && supplyAbovePor &&
                                 (st_r.seq == SEQ_FAST_SCAN || st_r.seq == SEQ_RUN) |=> st_r.low2)
    else $error("second low flag not set by scan");
  AST_THERMO_OFF: assert property (scanTick && !aboveLow1 && supplyAbovePor && st_r.seq == SEQ_RUN
                                   |=> !thermometerEnable)
    else $error("thermometer left on under low supply");
  AST_PON_KEEP: assert property (st_r.power_on_flag && supplyAbovePor && !sclRise |=> st_r.power_on_flag)
    else $error("power-on flag lost without a clear");
  AST_BACKUP: assert property (onBackup |-> !clockOutEnable && spiMisoOeN && trickleSelect == 4'h0)
    else $error("function left on in backup mode");
  AST_STICKY: assert property (supplyAbovePor && !sclRise && st_r.seq == SEQ_RUN
                               |=> (st_r.low1 || !$past(st_r.low1)) &&
                                   (st_r.low2 || !$past(st_r.low2)))
    else $error("low flag lost without a clear");

  CVR_READY_THERMO: cover property (st_r.seq == SEQ_MEASURE ##[1:50] deviceReady);
  CVR_LOW2_INT: cover property (st_r.low2 && !intN);
  CVR_BACKUP: cover property (deviceReady && onBackup);
  CVR_MEASURE_START: cover property (measureStart);
  CVR_FAST_TO_LOAD: cover property (fastScan ##1 nvmReadEnable);
endmodule

// ==== design/rpsm_regs.svh ====
`ifndef RPSM_REGS_SVH
`define RPSM_REGS_SVH

// Register addresses
`define RPSM_ADDR_CTRL_INT 6'h01
`define RPSM_ADDR_STATUS 6'h03
`define RPSM_ADDR_NV_CTRL 6'h30
`define RPSM_ADDR_XTAL_OFS 6'h31
`define RPSM_ADDR_CRYSTAL_QUADRATIC_COEFFICIENT 6'h32
`define RPSM_ADDR_CRYSTAL_TURNOVER_TEMPERATURE 6'h33

// Field positions
`define RPSM_ST_PON 5
`define RPSM_ST_LOW2 3
`define RPSM_ST_LOW1 2
`define RPSM_IE_LOW1 3
`define RPSM_IE_LOW2 2
`define RPSM_NV_THE 1
`define RPSM_NV_FD_LO 2
`define RPSM_NV_FD_HI 3
`define RPSM_NV_TRK_LO 4
`define RPSM_NV_TRK_HI 7
`define RPSM_T0_MSB 5
`define RPSM_SPI_RD_BIT 7

// Reset values
`define RPSM_CTRL_INT_RST 8'h00
`define RPSM_BYTE_ZERO 8'h00
`define RPSM_NV_CTRL_INIT 8'h02
`define RPSM_XTAL_OFS_INIT 8'h10
`define RPSM_CRYSTAL_QUADRATIC_COEFFICIENT_INIT 8'h80
`define RPSM_CRYSTAL_TURNOVER_TEMPERATURE_INIT 8'h19

// Counts and timing
`define RPSM_NV_WORDS 4
`define RPSM_SPI_LAST_BIT 4'h7
`define RPSM_CLK_HZ 20000000
`define RPSM_SLOW_SCAN_MS 1000
`define RPSM_FAST_SCAN_MS 1
`define RPSM_MS_PER_S 1000

`endif

// ==== design/rpsm_pkg.sv ====
package rpsm_pkg;

  typedef enum logic [2:0] {
    SEQ_HOLD = 3'h0,
    SEQ_DEFAULTS = 3'h1,
    SEQ_WAIT_OSC = 3'h2,
    SEQ_FAST_SCAN = 3'h3,
    SEQ_NVM_LOAD = 3'h4,
    SEQ_MEASURE = 3'h5,
    SEQ_RUN = 3'h6
  } rpsm_seq_t;

  typedef struct packed {
    rpsm_seq_t seq;
    logic [2:0] loadIdx;
    logic power_on_flag;
    logic low1;
    logic low2;
    logic below1;
    logic below2;
    logic measureStart;
    logic [7:0] ctrlInt;
    logic [7:0] nvCtrl;
    logic [7:0] xtalOffset;
    logic [7:0] xtalCoef;
    logic [7:0] xtalT0;
    logic sclPrev;
    logic [3:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [5:0] addr;
    logic cmdDone;
    logic isRead;
    logic misoOut;
  } rpsm_top_state_t;

endpackage

// ==== design/rpsm_nvm.sv ====
`timescale 1ns/1ps
`include "rpsm_regs.svh"

module rpsm_nvm #(
  parameter logic [7:0] INIT0 = `RPSM_NV_CTRL_INIT,
  parameter logic [7:0] INIT1 = `RPSM_XTAL_OFS_INIT,
  parameter logic [7:0] INIT2 = `RPSM_CRYSTAL_QUADRATIC_COEFFICIENT_INIT,
  parameter logic [7:0] INIT3 = `RPSM_CRYSTAL_TURNOVER_TEMPERATURE_INIT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [1:0] rdAddr,
  output logic [7:0] rdData
);
  typedef struct packed {
    logic [`RPSM_NV_WORDS-1:0][7:0] mem;
    logic [7:0] rdData;
  } rpsm_nvm_state_t;

  rpsm_nvm_state_t st_r;
  rpsm_nvm_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdData = st_r.mem[rdAddr];
    if (wrEn) begin
      st_nxt.mem[wrAddr] = wrData;
    end
  end

  // Contents model the factory-programmed control page
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r.mem <= {INIT3, INIT2, INIT1, INIT0};
      st_r.rdData <= `RPSM_BYTE_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
endmodule

// ==== design/rpsm_scan.sv ====
`timescale 1ns/1ps

module rpsm_scan #(
  parameter int COUNT_W = 25,
  parameter logic [COUNT_W-1:0] FAST_CYCLES = 20000,
  parameter logic [COUNT_W-1:0] SLOW_CYCLES = 20000000
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic enable,
  input wire logic fast,
  output logic tick
);
  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic tick;
    logic fastPrev;
  } rpsm_scan_state_t;

  rpsm_scan_state_t st_r;
  rpsm_scan_state_t st_nxt;
  logic [COUNT_W-1:0] period;

  always_comb begin
    period = fast ? FAST_CYCLES : SLOW_CYCLES;
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.fastPrev = fast;
    // A change of rate restarts the interval
    if (!enable || (fast != st_r.fastPrev)) begin
      st_nxt.count = '0;
    end else if (st_r.count >= period - 1'b1) begin
      st_nxt.count = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.count = st_r.count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// ==== test/rpsm_host.sv ====
`timescale 1ns/1ps

module rpsm_host (
  input wire logic clock,
  input wire logic spiMiso,
  input wire logic spiMisoOeN,
  output logic spiChipSelectN,
  output logic spiClock,
  output logic spiMosi
);
  logic idleLevel;
  logic misoLine;

  initial begin
    spiChipSelectN = 1'b1;
    spiClock = 1'b0;
    spiMosi = 1'b0;
    idleLevel = 1'b0;
  end

  // Undriven MISO shows a changing level, never the last bit
  always @(posedge clock) begin
    idleLevel <= ~idleLevel;
  end
  assign misoLine = spiMisoOeN ? idleLevel : spiMiso;

  // One byte, MSB first, each serial clock phase three system clocks long
  task automatic xbyte(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--) begin
      spiMosi = o[k];
      repeat (3) @(posedge clock);
      #1;
      i[k] = misoLine;
      spiClock = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      spiClock = 1'b0;
    end
  endtask

  // Command byte and one data byte inside one select
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    @(posedge clock);
    #1;
    spiChipSelectN = 1'b0;
    xbyte(cmd, junk);
    xbyte(wd, rd);
    repeat (3) @(posedge clock);
    #1;
    spiChipSelectN = 1'b1;
    spiMosi = ~spiMosi;
  endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`include "rpsm_regs.svh"

module testbench;
  localparam int FAST = 20;
  localparam int SLOW = 100;
  logic clock, rstn, supplyAbovePor, oscReady, aboveLow1, aboveLow2, onBackup, measureDone;
  logic spiChipSelectN, spiClock, spiMosi, spiMiso, spiMisoOeN, intN, fastScan, nvmReadEnable;
  logic measureStart, thermometerEnable, deviceReady, clockOutEnable;
  logic [1:0] clockOutSelect;
  logic [3:0] trickleSelect;
  logic [7:0] xtalOffset, xtalCoef, rd;
  logic [5:0] xtalT0;
  logic [7:0] ieVal [2] = '{8'h04, 8'h08};
  logic ieInt [2] = '{1'b1, 1'b0};
  int bad_count = 0;
  int total_checks = 0;
  int t0;

  rpsm_top #(.FAST_SCAN_CYCLES(FAST), .SLOW_SCAN_CYCLES(SLOW)) rpsm_top_inst (
    .clock, .rstn, .supplyAbovePor, .oscReady, .aboveLow1, .aboveLow2, .onBackup, .measureDone,
    .spiChipSelectN, .spiClock, .spiMosi, .spiMiso, .spiMisoOeN, .intN, .fastScan, .nvmReadEnable,
    .measureStart, .thermometerEnable, .deviceReady, .clockOutEnable, .clockOutSelect, .trickleSelect,
    .xtalOffset, .xtalCoef, .xtalT0
  );

  rpsm_host rpsm_host_inst (.clock, .spiMiso, .spiMisoOeN, .spiChipSelectN, .spiClock, .spiMosi);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    total_checks++;
    if ((got & mask) !== (exp & mask)) begin
      bad_count++;
      $display("MISMATCH at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    rpsm_host_inst.xfer({2'h0, a}, d, rd);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] mask);
    rpsm_host_inst.xfer({2'h2, a}, 8'h00, rd);
    chk8(rd, exp, mask);
  endtask

  // Counts cycles until the signal takes the level, bounded
  task automatic waitsig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 400) begin
      cyc(1);
      n++;
    end
    chk1(s, v);
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    supplyAbovePor = 1'b0;
    oscReady = 1'b0;
    aboveLow1 = 1'b0;
    aboveLow2 = 1'b0;
    onBackup = 1'b0;
    measureDone = 1'b0;
    cyc(5);
    chk1(intN, 1'b1);
    rstn = 1'b1;
    cyc(10);
    chk1(fastScan, 1'b0);
    chk1(deviceReady, 1'b0);
    supplyAbovePor = 1'b1;
    cyc(10);
    chk1(fastScan, 1'b0);
    rdchk(`RPSM_ADDR_STATUS, 8'h20, 8'h2C);
    wr(`RPSM_ADDR_CTRL_INT, 8'h0C);
    oscReady = 1'b1;
    cyc(2);
    chk1(fastScan, 1'b1);
    cyc(3 * FAST);
    chk1(intN, 1'b0);
    rdchk(`RPSM_ADDR_STATUS, 8'h2C, 8'h2C);
    aboveLow1 = 1'b1;
    aboveLow2 = 1'b1;
    waitsig(nvmReadEnable, 1'b1, t0);
    waitsig(measureStart, 1'b1, t0);
    chk1(fastScan, 1'b0);
    chk1(thermometerEnable, 1'b1);
    cyc(10);
    chk1(deviceReady, 1'b0);
    measureDone = 1'b1;
    cyc(2);
    chk1(deviceReady, 1'b1);
    chk1(clockOutEnable, 1'b1);
    chk8(xtalCoef, `RPSM_CRYSTAL_QUADRATIC_COEFFICIENT_INIT, 8'hFF);
    chk8({2'h0, xtalT0}, `RPSM_CRYSTAL_TURNOVER_TEMPERATURE_INIT, 8'h3F);
    chk8(xtalOffset, `RPSM_XTAL_OFS_INIT, 8'hFF);
    chk8({trickleSelect, clockOutSelect, 2'h0}, `RPSM_NV_CTRL_INIT, 8'hFC);
    rdchk(`RPSM_ADDR_STATUS, 8'h20, 8'h2C);
    aboveLow1 = 1'b0;
    waitsig(thermometerEnable, 1'b0, t0);
    aboveLow1 = 1'b1;
    waitsig(thermometerEnable, 1'b1, t0);
    chk1(t0 >= SLOW - 1 && t0 <= SLOW + 2, 1'b1);
    for (int e = 0; e < 2; e++) begin
      wr(`RPSM_ADDR_CTRL_INT, ieVal[e]);
      chk1(intN, ieInt[e]);
    end
    rdchk(`RPSM_ADDR_STATUS, 8'h24, 8'h2C);
    wr(`RPSM_ADDR_STATUS, 8'h00);
    rdchk(`RPSM_ADDR_STATUS, 8'h00, 8'h2C);
    chk1(intN, 1'b1);
    wr(`RPSM_ADDR_CRYSTAL_QUADRATIC_COEFFICIENT, 8'hA5);
    rdchk(`RPSM_ADDR_CRYSTAL_QUADRATIC_COEFFICIENT, 8'hA5, 8'hFF);
    chk8(xtalCoef, 8'hA5, 8'hFF);
    wr(`RPSM_ADDR_CRYSTAL_TURNOVER_TEMPERATURE, 8'hFF);
    rdchk(`RPSM_ADDR_CRYSTAL_TURNOVER_TEMPERATURE, 8'h3F, 8'hFF);
    chk8({2'h0, xtalT0}, 8'h3F, 8'hFF);
    wr(6'h3A, 8'h5A);
    rdchk(6'h3A, 8'h00, 8'hFF);
    wr(`RPSM_ADDR_CRYSTAL_QUADRATIC_COEFFICIENT, `RPSM_CRYSTAL_QUADRATIC_COEFFICIENT_INIT);
    wr(`RPSM_ADDR_CRYSTAL_TURNOVER_TEMPERATURE, `RPSM_CRYSTAL_TURNOVER_TEMPERATURE_INIT);
    wr(`RPSM_ADDR_NV_CTRL, 8'hFE);
    chk8({trickleSelect, clockOutSelect, 2'h0}, 8'hFC, 8'hFC);
    aboveLow1 = 1'b0;
    waitsig(thermometerEnable, 1'b0, t0);
    chk1(intN, 1'b0);
    onBackup = 1'b1;
    cyc(1);
    chk1(intN, 1'b0);
    chk1(clockOutEnable, 1'b0);
    chk8({trickleSelect, 4'h0}, 8'h00, 8'hF0);
    wr(`RPSM_ADDR_CTRL_INT, 8'h00);
    chk1(spiMisoOeN, 1'b1);
    chk1(intN, 1'b0);
    onBackup = 1'b0;
    aboveLow1 = 1'b1;
    rdchk(`RPSM_ADDR_CTRL_INT, 8'h08, 8'h0C);
    chk8({trickleSelect, 4'h0}, 8'hF0, 8'hF0);
    end_sim();
  end
endmodule
